// ==== dv/daot_rx_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Receiver beside the converter: grabs each output word
module daot_rx_model #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] data_a_i,
    input  wire logic [W-1:0] data_b_i,
    input  wire logic         valid_i,
    input  wire logic         odc_i
);
    logic           odc_prev_reg;  // Output clock one cycle back
    logic [2*W-1:0] got[$];        // Captured words, A above B

    // Capture on the output clock's rise, never on our own phase
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            odc_prev_reg <= 1'b0;
        end else begin
            odc_prev_reg <= odc_i;
            // Bubbles and wake-up words are dropped
            if (odc_i && !odc_prev_reg && valid_i) begin
                got.push_back({data_a_i, data_b_i});
            end
        end
    end
endmodule

`default_nettype wire

// ==== dv/daot_top_chk.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "daot_defines.svh"

module daot_top_chk #(
    parameter int DATA_W      = 16,
    parameter int WAKE_CYCLES = 20
) (
    input  wire logic                   CLK_SYS_I,
    input  wire logic                   RST_I,
    input  wire logic                   POWER_DOWN_I,
    input  wire logic                   DIFF_MODE_I,
    input  wire logic [`DAOT_DIV_W-1:0] DIV_SEL_I,
    input  wire logic                   DIV_SYNC_I,
    input  wire logic                   SERIAL_CLK_I,
    input  wire logic                   SERIAL_SELECT_N_I,
    input  wire logic                   SDIO_OE_O,
    input  wire logic [DATA_W-1:0]      DATA_A_O,
    input  wire logic [DATA_W-1:0]      DATA_B_O,
    input  wire logic                   DATA_VALID_O,
    input  wire logic                   OUTPUT_DATA_CLOCK_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    logic [5:0] stab_reg;  // Cycles since divider setup was disturbed
    int         gap_reg;   // Cycles since channel A last moved
    int         pd_reg;    // Cycles power-down pin held high
    int         wake_reg;  // Cycles since power-down pin dropped

    // Divider phase settles only after pins and sync sit still
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            stab_reg <= 6'h00;
        end else if ($changed(DIV_SEL_I) || $changed(DIFF_MODE_I) || DIV_SYNC_I) begin
            stab_reg <= 6'h00;
        end else if (stab_reg != 6'h3f) begin
            stab_reg <= stab_reg + 6'h01;
        end
    end

    // Spacing of channel A updates
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            gap_reg <= 0;
        end else begin
            gap_reg <= $changed(DATA_A_O) ? 0 : gap_reg + 1;
        end
    end

    // Power-down run and wake-up count, both saturating
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            pd_reg   <= 0;
            wake_reg <= WAKE_CYCLES;
        end else if (POWER_DOWN_I) begin
            pd_reg   <= (pd_reg < 15) ? pd_reg + 1 : pd_reg;
            wake_reg <= 0;
        end else begin
            pd_reg   <= 0;
            wake_reg <= (wake_reg < WAKE_CYCLES) ? wake_reg + 1 : wake_reg;
        end
    end

    // Channel A step in differential mode, ratio four
    sequence a_step_s;
        stab_reg >= 6'h14 && DIFF_MODE_I && DIV_SEL_I == 3'h3 && $changed(DATA_A_O);
    endsequence

    // Channel B holds for half a period after A
    sequence b_hold_s;
        !$changed(DATA_B_O) ##1 !$changed(DATA_B_O);
    endsequence

    pd_blank_a: assert property (pd_reg >= 14 |-> !DATA_VALID_O)
        else $error("valid output during power-down");
    wake_hold_a: assert property (!POWER_DOWN_I && wake_reg < WAKE_CYCLES |-> !DATA_VALID_O)
        else $error("valid output before wake-up time");
    conv_rate_a: assert property (stab_reg >= 6'h14 && $changed(DATA_A_O) |-> gap_reg >= int'(DIV_SEL_I))
        else $error("output faster than divided clock");
    diff_half_a: assert property (a_step_s |-> b_hold_s)
        else $error("channel B not half a period late");
    odc_div1_a: assert property (stab_reg >= 6'h2d && DIV_SEL_I == 3'h0 |-> OUTPUT_DATA_CLOCK_O)
        else $error("output clock toggles in divide-by-1");
    oe_turnon_a: assert property ($rose(SDIO_OE_O) |-> !SERIAL_SELECT_N_I && !$past(SERIAL_CLK_I, 1)
        && !$past(SERIAL_CLK_I, 2) && !$past(SERIAL_CLK_I, 3))
        else $error("data line turned on too early");
    oe_release_a: assert property ($rose(SERIAL_SELECT_N_I) |-> ##[0:5] !SDIO_OE_O)
        else $error("data line held after deselect");
    oe_idle_a: assert property (SERIAL_SELECT_N_I [*6] |-> !SDIO_OE_O)
        else $error("data line driven while idle");
    oe_fall_a: assert property ($fell(SDIO_OE_O) |-> SERIAL_CLK_I || SERIAL_SELECT_N_I)
        else $error("data line released off the rising phase");
endmodule

`default_nettype wire

// ==== dv/test_dual_adc_output_timing.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "daot_defines.svh"

module test_dual_adc_output_timing;
    import daot_pkg::*;

    localparam int WAKE = 20;             // Shortened wake-up count
    localparam int LAT  = `DAOT_LATENCY;  // Pipeline depth

    logic                   clk_sys = 1'b0;   // 250 MHz system clock
    logic                   rst = 1'b1;       // Reset, high active
    daot_sample_t           sample = '0;      // Word offered
    logic                   s_valid = 1'b0;   // Word offered strobe
    logic                   pd = 1'b0;        // Power-down pin
    logic                   diff = 1'b0;      // Differential mode pin
    logic [`DAOT_DIV_W-1:0] div_sel = 3'h0;   // Divider ratio minus one
    logic                   div_sync = 1'b0;  // Divider sync pin
    logic                   sclk = 1'b0;      // Serial clock, idles low
    logic                   sel_n = 1'b1;     // Serial select
    logic                   host_oe = 1'b0;   // Host drives data line
    logic                   host_d = 1'b0;    // Host data bit
    logic                   sdio_o, sdio_oe, ready, dvalid, odc;
    logic [15:0]            da, db;
    int                     bad_count = 0;
    int                     samples_checked = 0;
    wire logic              sdio_line;

    // Pull-up wins when nobody drives the line
    assign sdio_line = sdio_oe ? sdio_o : (host_oe ? host_d : 1'b1);

    always #2 clk_sys = ~clk_sys;

    daot_top #(.LATENCY(LAT), .WAKE_CYCLES(WAKE)) daot_top_inst (
        .CLK_SYS_I(clk_sys), .RST_I(rst), .SAMPLE_I(sample), .SAMPLE_VALID_I(s_valid),
        .SAMPLE_READY_O(ready), .POWER_DOWN_I(pd), .DIFF_MODE_I(diff), .DIV_SEL_I(div_sel),
        .DIV_SYNC_I(div_sync), .SERIAL_CLK_I(sclk), .SERIAL_SELECT_N_I(sel_n),
        .SDIO_I(sdio_line), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .DATA_A_O(da),
        .DATA_B_O(db), .DATA_VALID_O(dvalid), .OUTPUT_DATA_CLOCK_O(odc));

    daot_rx_model daot_rx_model_inst (.clk_i(clk_sys), .rst_i(rst), .data_a_i(da),
        .data_b_i(db), .valid_i(dvalid), .odc_i(odc));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One 24-bit frame; host lets go of the line before a read
    task automatic spi(input logic [15:0] instr, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] frame;
        logic        wr;
        frame = {instr, wd};
        wr = !instr[15];
        sel_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            host_oe = wr || i > 7;
            host_d = frame[i];
            repeat (8) @(negedge clk_sys);
            if (i < 8) rd[i] = sdio_line;
            sclk = 1'b1;
            @(negedge clk_sys);
            if (i == 8 && !wr) host_oe = 1'b0;
            repeat (7) @(negedge clk_sys);
        end
        repeat (8) @(negedge clk_sys);
        sel_n = 1'b1;
        sclk = 1'b0;
        host_oe = 1'b0;
        repeat (12) @(negedge clk_sys);
    endtask

    // Single word, divide-by-1, single-ended
    task automatic t_latency;
        int n;
        n = 0;
        sample = {16'h1234, 16'h5678};
        s_valid = 1'b1;
        @(negedge clk_sys);
        s_valid = 1'b0;
        while (!dvalid && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk("latency", n, LAT + 1);
        chk("word", {da, db}, 32'h12345678);
        $display("latency test done");
    endtask

    // Fill the FIFO until refused, then drain through the receiver
    task automatic t_stream;
        int n;
        int t;
        diff = 1'b1;
        div_sel = 3'h3;
        repeat (40) @(negedge clk_sys);
        daot_rx_model_inst.got.delete();
        n = 0;
        while (ready && n < 40) begin
            sample = {16'ha000 + 16'(n), 16'hb000 + 16'(n)};
            s_valid = 1'b1;
            n++;
            @(negedge clk_sys);
        end
        s_valid = 1'b0;
        chk("refused", ready, 1'b0);
        chk("taken", n >= `DAOT_FIFO_DEPTH, 1'b1);
        t = 0;
        while (daot_rx_model_inst.got.size() < n && t < 400) begin
            @(negedge clk_sys);
            t++;
        end
        chk("drained", daot_rx_model_inst.got.size(), n);
        foreach (daot_rx_model_inst.got[k]) begin
            chk("stream", daot_rx_model_inst.got[k], {16'ha000 + 16'(k), 16'hb000 + 16'(k)});
        end
        $display("stream test done");
    endtask

    // Output stays invalid through power-down and wake-up
    task automatic t_power;
        int n;
        diff = 1'b0;
        div_sel = 3'h0;
        sample = 32'hc0dec0de;
        s_valid = 1'b1;
        pd = 1'b1;
        repeat (30) @(negedge clk_sys);
        chk("pd valid", dvalid, 1'b0);
        pd = 1'b0;
        n = 0;
        while (!dvalid && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        chk("wake min", n >= WAKE, 1'b1);
        chk("wake max", n < WAKE + 40, 1'b1);
        s_valid = 1'b0;
        $display("power test done");
    endtask

    // Delay register keeps five bits; other addresses read zero
    task automatic t_serial;
        logic [7:0] rd;
        spi(16'h0017, 8'hf5, rd);
        spi(16'h8017, 8'h00, rd);
        chk("reg read", rd, 8'h15);
        spi(16'h8018, 8'h00, rd);
        chk("unmapped", rd, 8'h00);
        $display("serial test done");
    endtask

    // Output clock rise phase after a divider sync
    task automatic odc_phase(output int ph);
        int   n;
        logic prev;
        div_sync = 1'b1;
        @(negedge clk_sys);
        div_sync = 1'b0;
        n = 1;
        repeat (40) begin
            @(negedge clk_sys);
            n++;
        end
        prev = odc;
        while (n < 100) begin
            @(negedge clk_sys);
            n++;
            if (odc && !prev) break;
            prev = odc;
        end
        ph = n % 8;
    endtask

    // Three taps of delay shift the output clock three cycles
    task automatic t_odc;
        logic [7:0] rd;
        int         p0;
        int         p3;
        div_sel = 3'h7;
        spi(16'h0017, 8'h00, rd);
        odc_phase(p0);
        chk("sync phase", p0, 6);
        spi(16'h0017, 8'h03, rd);
        odc_phase(p3);
        chk("odc delay", (p3 - p0 + 8) % 8, 3);
        $display("output clock test done");
    endtask

    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        t_latency();
        t_stream();
        t_power();
        t_serial();
        t_odc();
        print_verdict();
    end

    // Whole run needs a few thousand cycles
    initial begin
        #80000;
        bad_count++;
        print_verdict();
    end
endmodule

bind daot_top daot_top_chk #(.DATA_W(DATA_W), .WAKE_CYCLES(WAKE_CYCLES)) daot_top_chk_inst (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .POWER_DOWN_I(POWER_DOWN_I), .DIFF_MODE_I(DIFF_MODE_I),
    .DIV_SEL_I(DIV_SEL_I), .DIV_SYNC_I(DIV_SYNC_I), .SERIAL_CLK_I(SERIAL_CLK_I),
    .SERIAL_SELECT_N_I(SERIAL_SELECT_N_I), .SDIO_OE_O(SDIO_OE_O), .DATA_A_O(DATA_A_O),
    .DATA_B_O(DATA_B_O), .DATA_VALID_O(DATA_VALID_O), .OUTPUT_DATA_CLOCK_O(OUTPUT_DATA_CLOCK_O));

`default_nettype wire

// ==== hdl/daot_defines.svh ====
`ifndef DAOT_DEFINES_SVH
`define DAOT_DEFINES_SVH

// Sample path
`define DAOT_DATA_W          16
`define DAOT_LATENCY         12
`define DAOT_FIFO_DEPTH      16

// Clocking
`define DAOT_CLK_MHZ         250
`define DAOT_CLK_NS          4
`define DAOT_MAX_IN_CLK_MHZ  625
`define DAOT_DIV_W           3

// Wake-up after power-down, microseconds
`define DAOT_WAKE_US         500

// Serial port turnaround, nanoseconds
`define DAOT_SDIO_EN_NS      10
`define DAOT_SDIO_EN_CYC     ((`DAOT_SDIO_EN_NS + `DAOT_CLK_NS - 1) / `DAOT_CLK_NS)

// Serial frame layout
`define DAOT_SPI_INSTR_BITS  16
`define DAOT_SPI_FRAME_BITS  24
`define DAOT_SPI_RW_BIT      15
`define DAOT_SPI_ADDR_W      13

// Output data clock delay register
`define DAOT_REG_ODC_DELAY   13'h0017
`define DAOT_ODC_DELAY_LSB   0
`define DAOT_ODC_DELAY_W     5
`define DAOT_ODC_DELAY_RST   5'h00

`endif

// ==== hdl/daot_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none

module daot_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         CLK_SYS_I,
    input  wire logic         RST_I,
    input  wire logic [W-1:0] IN_DATA_I,
    input  wire logic         IN_VALID_I,
    output logic              IN_READY_O,
    output logic [W-1:0]      OUT_DATA_O,
    output logic              OUT_VALID_O,
    input  wire logic         OUT_READY_I
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];   // Storage words
    logic [AW-1:0] wr_ptr_reg;       // Next write slot
    logic [AW-1:0] rd_ptr_reg;       // Next read slot
    logic [AW:0]   count_reg;        // Words held
    logic          push;
    logic          pop;

    // Honest flags straight from the fill count
    assign IN_READY_O  = (count_reg != (AW+1)'(DEPTH));
    assign OUT_VALID_O = (count_reg != '0);
    assign OUT_DATA_O  = mem_reg[rd_ptr_reg];
    assign push        = IN_VALID_I && IN_READY_O;
    assign pop         = OUT_VALID_O && OUT_READY_I;

    // Storage write, no reset needed on data
    always_ff @(posedge CLK_SYS_I) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= IN_DATA_I;
        end
    end

    // Pointers and fill level
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== hdl/daot_pkg.sv ====
`include "daot_defines.svh"

package daot_pkg;

    // One converted pair, channel A and channel B
    typedef struct packed {
        logic [`DAOT_DATA_W-1:0] ch_a;
        logic [`DAOT_DATA_W-1:0] ch_b;
    } daot_sample_t;

    // Static configuration pins after synchronising
    typedef struct packed {
        logic                   power_down;
        logic                   diff_mode;
        logic [`DAOT_DIV_W-1:0] div_sel;
    } daot_cfg_t;

    // Serial port states
    typedef enum logic [3:0] {
        SP_IDLE  = 4'h1,
        SP_INSTR = 4'h2,
        SP_WDATA = 4'h4,
        SP_RDATA = 4'h8
    } daot_spi_state_t;

endpackage

// ==== hdl/daot_top.sv ====
// What this block does
// RL1 - Single-ended: sample out twelve conversions later
// RL2 - Differential: A at twelve, B half later
// RL3 - Output invalid for wake time after power-down
// RL4 - Conversion rate is clock over ratio 1-8
// RL5 - Five-bit serial register delays output data clock
// RL6 - Divider sync input sampled on rising clock
// RL7 - Serial write data captured on rising clock
// RL8 - Read turn-on after falling edge, ten ns
// RL9 - Release data line after last rising edge
// RL10 - Receiver captures with output data clock
`timescale 1ns/10ps
`default_nettype none

`include "daot_defines.svh"

module daot_top
    import daot_pkg::*;
#(
    parameter int DATA_W      = `DAOT_DATA_W,
    parameter int LATENCY     = `DAOT_LATENCY,
    parameter int FIFO_DEPTH  = `DAOT_FIFO_DEPTH,
    parameter int WAKE_CYCLES = `DAOT_WAKE_US * `DAOT_CLK_MHZ
) (
    input  wire logic                    CLK_SYS_I,
    input  wire logic                    RST_I,
    input  wire daot_sample_t            SAMPLE_I,
    input  wire logic                    SAMPLE_VALID_I,
    output logic                         SAMPLE_READY_O,
    input  wire logic                    POWER_DOWN_I,
    input  wire logic                    DIFF_MODE_I,
    input  wire logic [`DAOT_DIV_W-1:0]  DIV_SEL_I,
    input  wire logic                    DIV_SYNC_I,
    input  wire logic                    SERIAL_CLK_I,
    input  wire logic                    SERIAL_SELECT_N_I,
    input  wire logic                    SDIO_I,
    output logic                         SDIO_O,
    output logic                         SDIO_OE_O,
    output logic [DATA_W-1:0]            DATA_A_O,
    output logic [DATA_W-1:0]            DATA_B_O,
    output logic                         DATA_VALID_O,
    output logic                         OUTPUT_DATA_CLOCK_O
);

    localparam int SYNC_W  = 9;
    localparam int WAKE_W  = $clog2(WAKE_CYCLES + 1);
    localparam int TAPS    = 1 << `DAOT_ODC_DELAY_W;
    localparam int SAMP_W  = $bits(daot_sample_t);

    // Two-stage synchroniser for every pin input
    logic [SYNC_W-1:0] sync1_reg;        // First stage, read only by second
    logic [SYNC_W-1:0] sync2_reg;        // Safe to use
    logic [2:0]        edge_prev_reg;    // Previous sync, sclk, select
    daot_cfg_t         cfg;              // Static pins after sync
    logic              div_sync_s;
    logic              sclk_s;
    logic              sel_n_s;
    logic              sdio_s;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            sync1_reg     <= 9'h002;               // Idle pin levels, select high
            sync2_reg     <= 9'h002;
            edge_prev_reg <= 3'h1;
        end else begin
            sync1_reg     <= {POWER_DOWN_I, DIFF_MODE_I, DIV_SEL_I, DIV_SYNC_I,
                              SERIAL_CLK_I, SERIAL_SELECT_N_I, SDIO_I};
            sync2_reg     <= sync1_reg;
            edge_prev_reg <= {div_sync_s, sclk_s, sel_n_s};
        end
    end

    assign cfg        = daot_cfg_t'(sync2_reg[8:4]);
    assign div_sync_s = sync2_reg[3];
    assign sclk_s     = sync2_reg[2];
    assign sel_n_s    = sync2_reg[1];
    assign sdio_s     = sync2_reg[0];

    logic sync_rise;
    logic sclk_rise;
    logic sclk_fall;
    assign sync_rise = div_sync_s && !edge_prev_reg[2];
    assign sclk_rise = sclk_s && !edge_prev_reg[1];
    assign sclk_fall = !sclk_s && edge_prev_reg[1];

    // Divider: one conversion every div_sel+1 input clocks
    logic [`DAOT_DIV_W-1:0] div_cnt_reg;   // Phase within conversion period
    logic [`DAOT_DIV_W-1:0] half_phase;    // Mid-period phase
    logic                   conv_stb;      // Conversion edge
    logic                   mid_stb;       // Opposite clock phase

    assign half_phase = 3'((({1'b0, cfg.div_sel} + 4'h1) >> 1));
    assign conv_stb   = (div_cnt_reg == '0);
    assign mid_stb    = (div_cnt_reg == half_phase);

    // Input clock is bounded by DAOT_MAX_IN_CLK_MHZ; here it is the system clock
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            div_cnt_reg <= '0;
        end else if (sync_rise) begin
            div_cnt_reg <= '0;                                  // RL6
        end else if (div_cnt_reg >= cfg.div_sel) begin
            div_cnt_reg <= '0;                                  // RL4
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // Sample FIFO, drained one word per conversion edge
    logic [SAMP_W-1:0] fifo_data;
    logic              fifo_valid;

    daot_fifo #(
        .W     (SAMP_W),
        .DEPTH (FIFO_DEPTH)
    ) daot_fifo_inst (
        .CLK_SYS_I   (CLK_SYS_I),
        .RST_I       (RST_I),
        .IN_DATA_I   (SAMPLE_I),
        .IN_VALID_I  (SAMPLE_VALID_I),
        .IN_READY_O  (SAMPLE_READY_O),
        .OUT_DATA_O  (fifo_data),
        .OUT_VALID_O (fifo_valid),
        .OUT_READY_I (conv_stb)
    );

    // Pipeline of LATENCY conversion stages, advanced per conversion
    daot_sample_t pipe_reg  [LATENCY];   // Sample per stage
    logic         pipe_v_reg[LATENCY];   // Stage holds real data

    genvar g;
    generate
        for (g = 0; g < LATENCY; g++) begin : g_pipe
            always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
                if (RST_I) begin
                    pipe_reg[g]   <= '0;
                    pipe_v_reg[g] <= 1'b0;
                end else if (conv_stb) begin
                    if (g == 0) begin
                        pipe_reg[g]   <= daot_sample_t'(fifo_data);
                        pipe_v_reg[g] <= fifo_valid;
                    end else begin
                        // Index clamped so the head stage never names a stage below zero
                        pipe_reg[g]   <= pipe_reg[(g > 0) ? g-1 : 0];
                        pipe_v_reg[g] <= pipe_v_reg[(g > 0) ? g-1 : 0];
                    end
                end
            end
        end
    endgenerate

    // Wake-up guard after power-down
    logic [WAKE_W-1:0] wake_cnt_reg;     // Remaining wake cycles
    logic              pd_prev_reg;      // Power-down seen last cycle
    logic              awake;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            wake_cnt_reg <= '0;
            pd_prev_reg  <= 1'b0;
        end else begin
            pd_prev_reg <= cfg.power_down;
            if (cfg.power_down) begin
                wake_cnt_reg <= '0;
            end else if (pd_prev_reg) begin
                wake_cnt_reg <= WAKE_W'(WAKE_CYCLES);            // RL3
            end else if (wake_cnt_reg != '0) begin
                wake_cnt_reg <= wake_cnt_reg - 1'b1;
            end
        end
    end

    assign awake = !cfg.power_down && !pd_prev_reg && (wake_cnt_reg == '0);

    // Output bus; B waits half a period in differential mode
    logic [DATA_W-1:0] b_hold_reg;       // B parked until opposite phase

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            DATA_A_O     <= '0;
            DATA_B_O     <= '0;
            b_hold_reg   <= '0;
            DATA_VALID_O <= 1'b0;
        end else begin
            if (conv_stb) begin
                DATA_A_O     <= pipe_reg[LATENCY-1].ch_a;         // RL1 RL2
                b_hold_reg   <= pipe_reg[LATENCY-1].ch_b;
                DATA_VALID_O <= pipe_v_reg[LATENCY-1] && awake;   // RL3
                if (!cfg.diff_mode) begin
                    DATA_B_O <= pipe_reg[LATENCY-1].ch_b;         // RL1
                end
            end
            // At divide-by-one there is no half phase; B lands with A
            if (cfg.diff_mode && mid_stb) begin
                DATA_B_O <= conv_stb ? pipe_reg[LATENCY-1].ch_b : b_hold_reg; // RL2
            end
        end
    end

    // Output data clock: high in first half of period, then delayed
    logic                          odc_base_reg;   // Undelayed clock
    logic [TAPS-1:0]               odc_line_reg;   // Delay taps
    logic [`DAOT_ODC_DELAY_W-1:0]  odc_delay_reg;  // Tap select from serial port

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            odc_base_reg        <= 1'b0;
            odc_line_reg        <= '0;
            OUTPUT_DATA_CLOCK_O <= 1'b0;
        end else begin
            // Divide-by-one cannot toggle inside one cycle; clock then stays high
            odc_base_reg        <= (div_cnt_reg < half_phase) || (cfg.div_sel == '0);
            odc_line_reg        <= {odc_line_reg[TAPS-2:0], odc_base_reg};
            OUTPUT_DATA_CLOCK_O <= odc_line_reg[odc_delay_reg];  // RL5
        end
    end

    // Serial control port
    daot_spi_state_t               sp_state_reg;
    logic [4:0]                    bit_cnt_reg;    // Bits sampled in frame
    logic [`DAOT_SPI_INSTR_BITS-1:0] shift_reg;    // Incoming bits
    logic [7:0]                    rd_byte_reg;    // Byte being read out
    logic [1:0]                    en_wait_reg;    // Turn-on delay count
    logic [`DAOT_SPI_ADDR_W-1:0]   addr_reg;       // Address held for the data phase
    logic [`DAOT_SPI_ADDR_W-1:0]   addr_now;       // Address as the last instruction bit lands
    logic                          addr_hit;

    // Only the delay register answers on the serial port
    function automatic logic is_delay_reg(input logic [`DAOT_SPI_ADDR_W-1:0] addr);
        return addr == `DAOT_REG_ODC_DELAY;
    endfunction

    // Data bits keep shifting in, so the address is held apart
    assign addr_now = {shift_reg[`DAOT_SPI_ADDR_W-2:0], sdio_s};
    assign addr_hit = is_delay_reg(addr_reg);

    // Frame state and bit capture on rising serial clock
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            sp_state_reg  <= SP_IDLE;
            bit_cnt_reg   <= '0;
            shift_reg     <= '0;
            addr_reg      <= '0;
            odc_delay_reg <= `DAOT_ODC_DELAY_RST;
        end else if (sel_n_s) begin
            sp_state_reg <= SP_IDLE;
            bit_cnt_reg  <= '0;
        end else if (sclk_rise) begin
            shift_reg   <= {shift_reg[`DAOT_SPI_INSTR_BITS-2:0], sdio_s}; // RL7
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            unique case (sp_state_reg)
                SP_IDLE, SP_INSTR: begin
                    sp_state_reg <= SP_INSTR;
                    if (bit_cnt_reg == 5'(`DAOT_SPI_INSTR_BITS - 1)) begin
                        addr_reg     <= addr_now;
                        sp_state_reg <= shift_reg[`DAOT_SPI_RW_BIT-1] ? SP_RDATA : SP_WDATA;
                    end
                end
                SP_WDATA: begin
                    if (bit_cnt_reg == 5'(`DAOT_SPI_FRAME_BITS - 1)) begin
                        sp_state_reg <= SP_IDLE;
                        if (addr_hit) begin
                            odc_delay_reg <= {shift_reg[3:0], sdio_s}; // RL5 RL7
                        end
                    end
                end
                SP_RDATA: begin
                    if (bit_cnt_reg == 5'(`DAOT_SPI_FRAME_BITS - 1)) begin
                        sp_state_reg <= SP_IDLE;
                    end
                end
            endcase
        end
    end

    // Read data driven on falling serial clock, enabled after turn-on delay
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            SDIO_O      <= 1'b0;
            SDIO_OE_O   <= 1'b0;
            rd_byte_reg <= '0;
            en_wait_reg <= '0;
        end else if (sel_n_s || sp_state_reg != SP_RDATA) begin
            SDIO_OE_O   <= 1'b0;                                 // RL9
            en_wait_reg <= '0;
            // Last load happens on the edge that completes the instruction
            rd_byte_reg <= is_delay_reg(addr_now) ? 8'({3'h0, odc_delay_reg}) : 8'h00;
        end else begin
            if (sclk_fall) begin
                SDIO_O      <= rd_byte_reg[7];
                rd_byte_reg <= {rd_byte_reg[6:0], 1'b0};
                if (!SDIO_OE_O && en_wait_reg == '0) begin
                    en_wait_reg <= 2'(`DAOT_SDIO_EN_CYC);        // RL8
                end
            end
            if (en_wait_reg != '0) begin
                en_wait_reg <= en_wait_reg - 1'b1;
                if (en_wait_reg == 2'h1) begin
                    SDIO_OE_O <= 1'b1;                           // RL8
                end
            end
        end
    end

endmodule

`default_nettype wire
